// ### irq_flag_mask_defs.vh
`ifndef IRQ_FLAG_MASK_DEFS_VH
`define IRQ_FLAG_MASK_DEFS_VH

// nibble locations in low ram
`define LOC_IE_EXT0 10'h000
`define LOC_TIMER_A 10'h001
`define LOC_TIMER_BC 10'h002
`define LOC_TIMER_D_ADC 10'h003
`define LOC_EXT23 10'h022
`define LOC_SERIAL 10'h023
`define LOC_EDGE_FIRST 10'h026
`define LOC_EDGE_SECOND 10'h027

// bit positions inside the nibbles
`define BIT_IE 0
`define BIT_EXT0_FLAG 2
`define BIT_EXT0_MASK 3
`define BIT_EXT1_FLAG 0
`define BIT_EXT1_MASK 1
`define BIT_TA_FLAG 2
`define BIT_TA_MASK 3
`define BIT_TB_FLAG 0
`define BIT_TB_MASK 1
`define BIT_TC_FLAG 2
`define BIT_TC_MASK 3
`define BIT_TD_FLAG 0
`define BIT_TD_MASK 1
`define BIT_AD_FLAG 2
`define BIT_AD_MASK 3
`define BIT_EXT2_FLAG 0
`define BIT_EXT2_MASK 1
`define BIT_EXT3_FLAG 2
`define BIT_EXT3_MASK 3
`define BIT_EXT4_FLAG 0
`define BIT_EXT4_MASK 1
`define BIT_SER_FLAG 2
`define BIT_SER_MASK 3

// source index in the flag and mask vectors
`define SRC_EXT0 0
`define SRC_EXT1 1
`define SRC_EXT2 2
`define SRC_EXT3 3
`define SRC_EXT4 4
`define SRC_TA 5
`define SRC_TB 6
`define SRC_TC 7
`define SRC_TD 8
`define SRC_SER 9
`define SRC_AD 10
`define NUM_SRC 11

// reset values
`define RST_FLAGS 11'h000
`define RST_MASKS 11'h7ff
`define RST_IE 1'b0
`define RST_EDGE_SEL 4'h0

// edge codes
`define EDGE_NONE 2'b00
`define EDGE_FALL 2'b01
`define EDGE_RISE 2'b10
`define EDGE_BOTH 2'b11

// cycles after reset before the first compare is trusted
`define EDGE_SETTLE 2'h3

`endif

// ### pin_edge_detect.v
`default_nettype none

module pin_edge_detect (
	input wire i_clk,
	input wire i_rst,
	input wire i_pin,
	input wire [1:0] i_code,
	output wire o_edge
);

`include "irq_flag_mask_defs.vh"

reg sync1_r;
reg sync2_r;
reg prev_r;
reg [1:0] settle_r;
wire live;
wire rise;
wire fall;

// two-stage synchroniser, then one more sample to compare against
always @(posedge i_clk) begin
	if (i_rst) begin
		sync1_r <= 1'b1;
		sync2_r <= 1'b1;
		prev_r <= 1'b1;
	end else begin
		sync1_r <= i_pin;
		sync2_r <= sync1_r;
		prev_r <= sync2_r;
	end
end

// ignore compares until reset values have flushed out of the chain
always @(posedge i_clk) begin
	if (i_rst) begin
		settle_r <= 2'h0;
	end else if (settle_r != `EDGE_SETTLE) begin
		settle_r <= settle_r + 2'h1;
	end
end

assign live = (settle_r == `EDGE_SETTLE);
assign rise = live & sync2_r & ~prev_r;
assign fall = live & ~sync2_r & prev_r;

// code selects which edges count
assign o_edge = (i_code[0] & fall) | (i_code[1] & rise);

endmodule // pin_edge_detect

`default_nettype wire

// ### irq_flag_mask_edge_select.v
// How it works
// - external request flags read 1 when a request is pending, else 0
// - external mask bit 1 blocks its flag's request, 0 passes it
// - edge select first at 026: pin3 code bits 3:2, pin2 bits 1:0
// - edge select second at 027: capture code bits 3:2, pin4 bits 1:0
// - edge code 00 none, 01 falling, 10 rising, 11 both edges
// - timer a flag at 001 bit 2 sets on timer a overflow
// - timer a mask at 001 bit 3 blocks when 1
// - timer b flag at 002 bit 0 sets on timer b overflow
// - timer b mask at 002 bit 1 blocks when 1
// - timer c flag at 002 bit 2 sets on timer c overflow
// - timer c mask at 002 bit 3 blocks when 1
// - timer d flag at 003 bit 0: overflow, or capture edge in capture use
// - timer d mask at 003 bit 1 blocks when 1
// - serial flag at 023 bit 2 sets on transfer done or suspended
// - serial mask at 023 bit 3 blocks when 1
// - converter flag at 003 bit 2 sets when conversion finishes
// - converter mask at 003 bit 3 blocks when 1
// - request active when flag 1 and mask 0; serviced only if enable 1
// - reset clears enable and flags, sets all masks
// - software cannot set a flag; the service routine clears it
// - pins zero and one detect falling edges only
`default_nettype none

module irq_flag_mask_edge_select #(
	parameter ADDR_W = 10
) (
	input wire i_clk,
	input wire i_rst,
	input wire [ADDR_W-1:0] i_addr,
	input wire i_wr_en,
	input wire [3:0] i_wr_data,
	input wire i_rd_en,
	output reg [3:0] o_rd_data,
	input wire [4:0] i_ext_irq_pins_n,
	input wire i_timer_capture_pin,
	input wire i_capture_mode,
	input wire [3:0] i_timer_ovf,
	input wire i_serial_done,
	input wire i_serial_suspend,
	input wire i_adc_done,
	input wire i_ie_clear,
	output reg [10:0] o_req,
	output reg o_irq,
	output reg o_global_irq_enable
);

`include "irq_flag_mask_defs.vh"

reg [10:0] flag_r;
reg [10:0] flag_nxt;
reg [10:0] mask_r;
reg [10:0] mask_nxt;
reg ie_r;
reg ie_nxt;
reg [3:0] edge_select_first_r;
reg [3:0] edge_select_second_r;
reg [10:0] flag_clr;
reg [10:0] mask_we;
reg [10:0] mask_wd;
reg ie_we;
reg [10:0] set_vec;
reg [3:0] rd_nxt;
wire [5:0] pin_edge;
wire [11:0] edge_codes;
wire [5:0] pin_levels;

// pins zero and one have no selector and see falling edges only
assign edge_codes = {edge_select_second_r[3:2], edge_select_second_r[1:0],
	edge_select_first_r[3:2], edge_select_first_r[1:0],
	`EDGE_FALL, `EDGE_FALL};
assign pin_levels = {i_timer_capture_pin, i_ext_irq_pins_n};

// one detector per pin; index 5 is the capture pin
genvar g;
generate
	for (g = 0; g < 6; g = g + 1) begin : g_pin
		pin_edge_detect u_det (
			.i_clk(i_clk),
			.i_rst(i_rst),
			.i_pin(pin_levels[g]),
			.i_code(edge_codes[2*g+1:2*g]),
			.o_edge(pin_edge[g])
		);
	end
endgenerate

// hardware set sources, one per flag
always @* begin
	set_vec = 11'h000;
	set_vec[`SRC_EXT0] = pin_edge[0];
	set_vec[`SRC_EXT1] = pin_edge[1];
	set_vec[`SRC_EXT2] = pin_edge[2];
	set_vec[`SRC_EXT3] = pin_edge[3];
	set_vec[`SRC_EXT4] = pin_edge[4];
	set_vec[`SRC_TA] = i_timer_ovf[0];
	set_vec[`SRC_TB] = i_timer_ovf[1];
	set_vec[`SRC_TC] = i_timer_ovf[2];
	set_vec[`SRC_TD] = i_timer_ovf[3] | (i_capture_mode & pin_edge[5]);
	set_vec[`SRC_SER] = i_serial_done | i_serial_suspend;
	set_vec[`SRC_AD] = i_adc_done;
end

// write decode; writing 1 to a flag bit does nothing, 0 clears it
always @* begin
	flag_clr = 11'h000;
	mask_we = 11'h000;
	mask_wd = 11'h000;
	ie_we = 1'b0;
	if (i_wr_en) begin
		case (i_addr)
		`LOC_IE_EXT0: begin
			ie_we = 1'b1;
			flag_clr[`SRC_EXT0] = ~i_wr_data[`BIT_EXT0_FLAG];
			mask_we[`SRC_EXT0] = 1'b1;
			mask_wd[`SRC_EXT0] = i_wr_data[`BIT_EXT0_MASK];
		end
		`LOC_TIMER_A: begin
			flag_clr[`SRC_EXT1] = ~i_wr_data[`BIT_EXT1_FLAG];
			flag_clr[`SRC_TA] = ~i_wr_data[`BIT_TA_FLAG];
			mask_we[`SRC_EXT1] = 1'b1;
			mask_we[`SRC_TA] = 1'b1;
			mask_wd[`SRC_EXT1] = i_wr_data[`BIT_EXT1_MASK];
			mask_wd[`SRC_TA] = i_wr_data[`BIT_TA_MASK];
		end
		`LOC_TIMER_BC: begin
			flag_clr[`SRC_TB] = ~i_wr_data[`BIT_TB_FLAG];
			flag_clr[`SRC_TC] = ~i_wr_data[`BIT_TC_FLAG];
			mask_we[`SRC_TB] = 1'b1;
			mask_we[`SRC_TC] = 1'b1;
			mask_wd[`SRC_TB] = i_wr_data[`BIT_TB_MASK];
			mask_wd[`SRC_TC] = i_wr_data[`BIT_TC_MASK];
		end
		`LOC_TIMER_D_ADC: begin
			flag_clr[`SRC_TD] = ~i_wr_data[`BIT_TD_FLAG];
			flag_clr[`SRC_AD] = ~i_wr_data[`BIT_AD_FLAG];
			mask_we[`SRC_TD] = 1'b1;
			mask_we[`SRC_AD] = 1'b1;
			mask_wd[`SRC_TD] = i_wr_data[`BIT_TD_MASK];
			mask_wd[`SRC_AD] = i_wr_data[`BIT_AD_MASK];
		end
		`LOC_EXT23: begin
			flag_clr[`SRC_EXT2] = ~i_wr_data[`BIT_EXT2_FLAG];
			flag_clr[`SRC_EXT3] = ~i_wr_data[`BIT_EXT3_FLAG];
			mask_we[`SRC_EXT2] = 1'b1;
			mask_we[`SRC_EXT3] = 1'b1;
			mask_wd[`SRC_EXT2] = i_wr_data[`BIT_EXT2_MASK];
			mask_wd[`SRC_EXT3] = i_wr_data[`BIT_EXT3_MASK];
		end
		`LOC_SERIAL: begin
			flag_clr[`SRC_EXT4] = ~i_wr_data[`BIT_EXT4_FLAG];
			flag_clr[`SRC_SER] = ~i_wr_data[`BIT_SER_FLAG];
			mask_we[`SRC_EXT4] = 1'b1;
			mask_we[`SRC_SER] = 1'b1;
			mask_wd[`SRC_EXT4] = i_wr_data[`BIT_EXT4_MASK];
			mask_wd[`SRC_SER] = i_wr_data[`BIT_SER_MASK];
		end
		default: begin
			ie_we = 1'b0;
		end
		endcase
	end
end

// set beats clear so an event in the clearing cycle survives
always @* begin
	flag_nxt = (flag_r & ~flag_clr) | set_vec;
	mask_nxt = (mask_r & ~mask_we) | (mask_wd & mask_we);
	ie_nxt = ie_r;
	if (i_ie_clear) begin
		ie_nxt = 1'b0;
	end else if (ie_we) begin
		ie_nxt = i_wr_data[`BIT_IE];
	end
end

// read mux; edge selectors are write-only and read as zero
always @* begin
	rd_nxt = 4'h0;
	case (i_addr)
	`LOC_IE_EXT0: begin
		rd_nxt[`BIT_IE] = ie_r;
		rd_nxt[`BIT_EXT0_FLAG] = flag_r[`SRC_EXT0];
		rd_nxt[`BIT_EXT0_MASK] = mask_r[`SRC_EXT0];
	end
	`LOC_TIMER_A: begin
		rd_nxt[`BIT_EXT1_FLAG] = flag_r[`SRC_EXT1];
		rd_nxt[`BIT_EXT1_MASK] = mask_r[`SRC_EXT1];
		rd_nxt[`BIT_TA_FLAG] = flag_r[`SRC_TA];
		rd_nxt[`BIT_TA_MASK] = mask_r[`SRC_TA];
	end
	`LOC_TIMER_BC: begin
		rd_nxt[`BIT_TB_FLAG] = flag_r[`SRC_TB];
		rd_nxt[`BIT_TB_MASK] = mask_r[`SRC_TB];
		rd_nxt[`BIT_TC_FLAG] = flag_r[`SRC_TC];
		rd_nxt[`BIT_TC_MASK] = mask_r[`SRC_TC];
	end
	`LOC_TIMER_D_ADC: begin
		rd_nxt[`BIT_TD_FLAG] = flag_r[`SRC_TD];
		rd_nxt[`BIT_TD_MASK] = mask_r[`SRC_TD];
		rd_nxt[`BIT_AD_FLAG] = flag_r[`SRC_AD];
		rd_nxt[`BIT_AD_MASK] = mask_r[`SRC_AD];
	end
	`LOC_EXT23: begin
		rd_nxt[`BIT_EXT2_FLAG] = flag_r[`SRC_EXT2];
		rd_nxt[`BIT_EXT2_MASK] = mask_r[`SRC_EXT2];
		rd_nxt[`BIT_EXT3_FLAG] = flag_r[`SRC_EXT3];
		rd_nxt[`BIT_EXT3_MASK] = mask_r[`SRC_EXT3];
	end
	`LOC_SERIAL: begin
		rd_nxt[`BIT_EXT4_FLAG] = flag_r[`SRC_EXT4];
		rd_nxt[`BIT_EXT4_MASK] = mask_r[`SRC_EXT4];
		rd_nxt[`BIT_SER_FLAG] = flag_r[`SRC_SER];
		rd_nxt[`BIT_SER_MASK] = mask_r[`SRC_SER];
	end
	default: begin
		rd_nxt = 4'h0;
	end
	endcase
end

// state registers
always @(posedge i_clk) begin
	if (i_rst) begin
		flag_r <= `RST_FLAGS;
		mask_r <= `RST_MASKS;
		ie_r <= `RST_IE;
		edge_select_first_r <= `RST_EDGE_SEL;
		edge_select_second_r <= `RST_EDGE_SEL;
	end else begin
		flag_r <= flag_nxt;
		mask_r <= mask_nxt;
		ie_r <= ie_nxt;
		if (i_wr_en && i_addr == `LOC_EDGE_FIRST) begin
			edge_select_first_r <= i_wr_data;
		end
		if (i_wr_en && i_addr == `LOC_EDGE_SECOND) begin
			edge_select_second_r <= i_wr_data;
		end
	end
end

// outputs registered; requests lag the flags by one cycle
always @(posedge i_clk) begin
	if (i_rst) begin
		o_rd_data <= 4'h0;
		o_req <= 11'h000;
		o_irq <= 1'b0;
		o_global_irq_enable <= 1'b0;
	end else begin
		if (i_rd_en) begin
			o_rd_data <= rd_nxt;
		end
		o_req <= flag_r & ~mask_r;
		o_irq <= ie_r & (|(flag_r & ~mask_r));
		o_global_irq_enable <= ie_r;
	end
end

endmodule // irq_flag_mask_edge_select

`default_nettype wire

// ### irq_flag_mask_edge_select_assertions.sv
`default_nettype none
module irq_fmes_checker #(
	parameter ADDR_W = 10
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [3:0] o_rd_data,
	input wire logic [3:0] i_timer_ovf,
	input wire logic i_serial_done,
	input wire logic i_serial_suspend,
	input wire logic i_adc_done,
	input wire logic i_ie_clear,
	input wire logic [10:0] o_req,
	input wire logic o_irq,
	input wire logic o_global_irq_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// only a software write may take a request away
	// a write lands in the flags one edge later and in o_req one more
	chk_req_no_drop: assert property (!$past(i_wr_en, 2) |->
		(o_req & $past(o_req)) == $past(o_req)) else $error("req drop");
	chk_irq_gate: assert property (
		o_irq == (o_global_irq_enable && |o_req)) else $error("irq");
	chk_ie_clear: assert property (i_ie_clear |-> ##2
		!(o_global_irq_enable || o_irq)) else $error("ie clear");
	// a request rises only from its event or an unmasking write
	chk_ta_rise: assert property ($rose(o_req[5]) |->
		$past(i_timer_ovf[0], 2) || $past(i_wr_en, 2)) else $error("ta");
	chk_tb_rise: assert property ($rose(o_req[6]) |->
		$past(i_timer_ovf[1], 2) || $past(i_wr_en, 2)) else $error("tb");
	chk_ser_rise: assert property ($rose(o_req[9]) |->
		$past(i_serial_done, 2) || $past(i_serial_suspend, 2) ||
		$past(i_wr_en, 2)) else $error("ser");
	chk_adc_rise: assert property ($rose(o_req[10]) |->
		$past(i_adc_done, 2) || $past(i_wr_en, 2)) else $error("adc");
	chk_edge_wo: assert property (
		i_rd_en && i_addr[9:1] == 9'h013 |=> o_rd_data == 4'h0)
		else $error("wo read");
endmodule // irq_fmes_checker
bind irq_flag_mask_edge_select irq_fmes_checker #(.ADDR_W(ADDR_W)) chk_i (.*);
`default_nettype wire

// ### irq_src_model.sv
`default_nettype none
// far side: pins idle high, events one cycle wide
module irq_src_model (
	input wire logic i_clk,
	input wire logic [6:0] i_ev,
	input wire logic [5:0] i_tgl,
	output var logic [5:0] o_pins = 6'h3f,
	output var logic [6:0] o_ev = 7'h00
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [12:0] cmd_r = 13'h0000;
	// launch on the far edge so the block never races its inputs
	always @(posedge i_clk) cmd_r <= {i_tgl, i_ev};
	always @(negedge i_clk) begin
		o_ev <= cmd_r[6:0];
		o_pins <= o_pins ^ cmd_r[12:7];
	end
endmodule // irq_src_model
`default_nettype wire

// ### irq_flag_mask_edge_select_test.sv
`default_nettype none
module irq_flag_mask_edge_select_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk = 0, i_rst = 1, i_wr_en = 0, i_rd_en = 0;
	logic i_capture_mode = 0, i_ie_clear = 0, ie = 0;
	logic [9:0] i_addr = 10'h000;
	logic [3:0] i_wr_data = 4'h0, o_rd_data;
	logic [6:0] ev = 7'h00, evo;
	logic [5:0] tgl = 6'h00, pins;
	logic [10:0] o_req, f = 11'h000, m = 11'h7ff;
	logic o_irq, o_global_irq_enable;
	int err_count = 0, num_checks = 0, c, j, k;
	int unsigned seed = 36133, r;
	// nibble map: low pair and high pair sources, -1 is the enable bit
	int lo[6] = '{-1, 1, 6, 8, 2, 4};
	int hi[6] = '{0, 5, 7, 10, 3, 9};
	int sr[7] = '{5, 6, 7, 8, 9, 9, 10};
	logic [9:0] ad[6] = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h022,
		10'h023};
	irq_flag_mask_edge_select dut (.*, .i_ext_irq_pins_n(pins[4:0]),
		.i_timer_capture_pin(pins[5]), .i_timer_ovf(evo[3:0]),
		.i_serial_done(evo[4]), .i_serial_suspend(evo[5]),
		.i_adc_done(evo[6]));
	irq_src_model src (.i_clk(i_clk), .i_ev(ev), .i_tgl(tgl),
		.o_pins(pins), .o_ev(evo));
	function automatic int unsigned xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(logic [12:0] s, logic [12:0] e);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %0t got %h want %h", $time, s, e);
		end
	endtask
	task automatic wrap_up();
		if (err_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// outputs lag state by a cycle, so waits cover the pipeline
	task automatic wr(logic [9:0] a, logic [3:0] d);
		i_addr = a;
		i_wr_data = d;
		i_wr_en = 1;
		@(negedge i_clk) i_wr_en = 0;
		repeat (2) @(negedge i_clk);
	endtask
	task automatic mw(int k, logic [3:0] d);
		wr(ad[k], d);
		if (lo[k] < 0) ie = d[0];
		else begin
			m[lo[k]] = d[1];
			f[lo[k]] &= d[0];
		end
		m[hi[k]] = d[3];
		f[hi[k]] &= d[2];
	endtask
	task automatic rd(logic [9:0] a, logic [3:0] e);
		i_addr = a;
		i_rd_en = 1;
		@(negedge i_clk) i_rd_en = 0;
		chk(o_rd_data, e);
	endtask
	function automatic logic [3:0] nib(int k);
		return {m[hi[k]], f[hi[k]],
			lo[k] < 0 ? {1'b0, ie} : {m[lo[k]], f[lo[k]]}};
	endfunction
	task automatic fire(int b);
		ev = 7'h01 << b;
		@(negedge i_clk) ev = 7'h00;
		repeat (3) @(negedge i_clk);
		f[sr[b]] = 1;
	endtask
	task automatic outs();
		chk({o_global_irq_enable, o_irq, o_req},
			{ie, ie && |(f & ~m), f & ~m});
	endtask
	initial begin
		forever #5 i_clk = ~i_clk;
	end
	initial begin
		repeat (5) @(negedge i_clk);
		i_rst = 0;
		// reset image, write-only and unmapped reads
		outs();
		for (k = 0; k < 6; k++) rd(ad[k], nib(k));
		rd(10'h026, 4'h0);
		rd(10'h027, 4'h0);
		rd(10'h3ff, 4'h0);
		// unmask all, enable, fire every timer, serial and converter event
		for (k = 0; k < 6; k++) mw(k, 4'h1);
		for (k = 0; k < 7; k++) fire(k);
		outs();
		i_ie_clear = 1;
		@(negedge i_clk) i_ie_clear = 0;
		repeat (2) @(negedge i_clk);
		ie = 0;
		outs();
		// random nibbles: masks move, written ones never set a flag
		for (j = 0; j < 40; j++) begin
			r = xs();
			k = r % 6;
			mw(k, r[7:4]);
			fire(r[10:8] % 7);
			rd(ad[k], nib(k));
			outs();
		end
		// every edge code on pins 2-4 and capture, both directions
		for (k = 0; k < 6; k++) mw(k, 4'h0);
		for (c = 0; c < 4; c++) begin
			r = xs();
			i_capture_mode = r[0];
			wr(10'h026, {c[1:0], c[1:0]});
			wr(10'h027, {c[1:0], c[1:0]});
			for (j = 0; j < 2; j++) begin
				tgl = 6'h3f;
				@(negedge i_clk) tgl = 6'h00;
				repeat (8) @(negedge i_clk);
				f[1:0] |= {2{j == 0}};
				r = c == 3 || c == 1 + j;
				f[4:2] |= {3{r[0]}};
				f[8] |= r[0] & i_capture_mode;
				outs();
			end
		end
		wrap_up();
	end
endmodule // irq_flag_mask_edge_select_test
`default_nettype wire
